// >>> jtp_ctl_if.sv
/*
 * Carrier between the top level and the controller state machine: test
 * clock rise enable, synchronised pin levels and the current state.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/10ps
`default_nettype none

interface jtp_ctl_if;
   logic                   tck_rise;   // one-cycle pulse per test clock rise
   logic                   tms;        // synchronised mode select
   logic                   trst_n;     // synchronised test reset, low active
   jtp_pkg::jtp_state_type state;      // current controller state

   modport fsm (
      input  tck_rise,
      input  tms,
      input  trst_n,
      output state
   );

   modport top (
      output tck_rise,
      output tms,
      output trst_n,
      input  state
   );
endinterface : jtp_ctl_if

`default_nettype wire

// >>> jtp_host_model.sv
/* test host model: makes the 48 ns test clock only within frames.
   Assumes the caller steps it one test clock at a time. */
`timescale 1ns/10ps
`default_nettype none
module jtp_host_model (
   output logic      o_tck,   // test clock, idles low
   output logic      o_tms,   // mode select
   output logic      o_tdi,   // data to the port
   input wire logic  i_tdo,   // data from the port
   input wire logic  i_tdo_oe // port drives data
);
   localparam int HALF_NS = 24; // half of the test clock period
   logic wire_w; // level seen on the data line
   // a released line floats to the pad pull-up
   assign wire_w = i_tdo_oe ? i_tdo : 1'b1;
   // idle inputs rest at their pull-up level
   initial
   begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b1;
   end
   // inputs change at the fall, data is read just before the rise
   task step(input logic tms, input logic tdi, input int hold,
             output logic tdo, output logic oe);
      o_tms = tms;
      o_tdi = tdi;
      #(HALF_NS);
      tdo = wire_w;
      oe = i_tdo_oe;
      o_tck = 1'b1;
      #(HALF_NS + hold); // hold stops the clock high
      o_tck = 1'b0;
   endtask : step
endmodule : jtp_host_model
`default_nettype wire

// >>> jtp_pkg.sv
/*
 * Constants, encodings and the controller state type for the test access
 * port. Assumes nothing of its surroundings; every other file uses it by
 * scoped name only.
 */
`default_nettype none

package jtp_pkg;

   // instruction chain length and instruction codes
   localparam int          IR_W       = 4;
   localparam logic [3:0]  IR_EXTEST  = 4'h0;
   localparam logic [3:0]  IR_INTEST  = 4'h1;
   localparam logic [3:0]  IR_SAMPLE  = 4'h2;
   localparam logic [3:0]  IR_IDCODE  = 4'he;
   localparam logic [3:0]  IR_BYPASS  = 4'hf;
   // fixed pattern loaded into the instruction chain on capture
   localparam logic [3:0]  IR_CAPTURE = 4'h1;
   // value loaded into the bypass stage on capture
   localparam logic [0:0]  BYP_CAPTURE = 1'h0;

   // tms high edges that reach reset from any state
   localparam int          TMS_RESET_EDGES = 5;

   // pad configuration after reset: pull-ups on, pull-downs off
   localparam int          PIN_COUNT  = 5;
   localparam logic [4:0]  PULLUP_RST = 5'h1f;
   localparam logic [4:0]  PULLDN_RST = 5'h00;

   // the sixteen controller states
   typedef enum logic [3:0] {
      ST_RESET,
      ST_IDLE,
      ST_SEL_DR,
      ST_CAP_DR,
      ST_SHIFT_DR,
      ST_EXIT1_DR,
      ST_PAUSE_DR,
      ST_EXIT2_DR,
      ST_UPD_DR,
      ST_SEL_IR,
      ST_CAP_IR,
      ST_SHIFT_IR,
      ST_EXIT1_IR,
      ST_PAUSE_IR,
      ST_EXIT2_IR,
      ST_UPD_IR
   } jtp_state_type;

endpackage : jtp_pkg

`default_nettype wire

// >>> jtp_shift_reg.sv
/*
 * One serial chain with its parallel load register. Shifts toward bit 0,
 * new bits entering at the top. Assumes the strobes are one-cycle enables
 * on the system clock and never two at once.
 */
`timescale 1ns/10ps
`default_nettype none

module jtp_shift_reg #(
   parameter int           W       = 4,          // chain length
   parameter logic [W-1:0] RST_VAL = '0          // parallel reset value
) (
   input  wire logic          i_clk,             // system clock
   input  wire logic          i_rst,             // async reset, high
   input  wire logic          i_hold,            // force parallel to reset
   input  wire logic          i_capture,         // load sampled data
   input  wire logic          i_shift,           // shift one bit
   input  wire logic          i_update,          // copy chain to parallel
   input  wire logic          i_tdi,             // serial in
   input  wire logic [W-1:0]  i_cap_data,        // data for capture
   output logic               o_so,              // serial out, bit 0
   output logic [W-1:0]       o_par              // parallel register
);

   initial
   begin
      if (W < 1)
         $error("chain length must be at least one");
   end

   logic [W-1:0] sh_q;
   logic [W-1:0] sh_d;
   logic [W:0]   joined;
   logic [W-1:0] par_q;
   logic [W-1:0] par_d;

   // shift through a joined vector so a one-bit chain needs no special case
   assign joined = {i_tdi, sh_q};
   assign sh_d   = i_capture ? i_cap_data :                 // [R11]
                   i_shift   ? joined[W:1] :                // [R11]
                   sh_q;
   // parallel register moves only on update; hold overrides it
   assign par_d  = i_hold   ? RST_VAL :                     // [R03]
                   i_update ? sh_q    :                     // [R12]
                   par_q;

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         sh_q  <= '0;
         par_q <= RST_VAL;
      end
      else
      begin
         sh_q  <= sh_d;
         par_q <= par_d;
      end
   end

   assign o_so  = sh_q[0];
   assign o_par = par_q;

endmodule : jtp_shift_reg

`default_nettype wire

// >>> jtp_tap_fsm.sv
/*
 * Test access port controller state machine. Steps once per test clock
 * rise enable. Assumes the enable and mode select come already
 * synchronised to the system clock, in step with each other.
 */
`timescale 1ns/10ps
`default_nettype none

module jtp_tap_fsm (
   input  wire logic  i_clk,           // system clock
   input  wire logic  i_rst,           // power-on reset, async high
   jtp_ctl_if.fsm     ctl              // rise enable, pins and state
);

   jtp_pkg::jtp_state_type state_q;
   jtp_pkg::jtp_state_type state_d;
   jtp_pkg::jtp_state_type step;

   // next state from the current one and the sampled mode select
   always_comb
   begin
      step = jtp_pkg::ST_RESET;
      case (state_q)
         jtp_pkg::ST_RESET:
            step = ctl.tms ? jtp_pkg::ST_RESET : jtp_pkg::ST_IDLE;
         jtp_pkg::ST_IDLE:
            step = ctl.tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
         jtp_pkg::ST_SEL_DR:
            step = ctl.tms ? jtp_pkg::ST_SEL_IR : jtp_pkg::ST_CAP_DR;
         jtp_pkg::ST_CAP_DR:
            step = ctl.tms ? jtp_pkg::ST_EXIT1_DR : jtp_pkg::ST_SHIFT_DR;
         jtp_pkg::ST_SHIFT_DR:
            step = ctl.tms ? jtp_pkg::ST_EXIT1_DR : jtp_pkg::ST_SHIFT_DR;
         jtp_pkg::ST_EXIT1_DR:
            step = ctl.tms ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_PAUSE_DR;
         jtp_pkg::ST_PAUSE_DR:
            step = ctl.tms ? jtp_pkg::ST_EXIT2_DR : jtp_pkg::ST_PAUSE_DR;
         jtp_pkg::ST_EXIT2_DR:
            step = ctl.tms ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_SHIFT_DR;
         jtp_pkg::ST_UPD_DR:
            step = ctl.tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
         jtp_pkg::ST_SEL_IR:
            step = ctl.tms ? jtp_pkg::ST_RESET : jtp_pkg::ST_CAP_IR;
         jtp_pkg::ST_CAP_IR:
            step = ctl.tms ? jtp_pkg::ST_EXIT1_IR : jtp_pkg::ST_SHIFT_IR;
         jtp_pkg::ST_SHIFT_IR:
            step = ctl.tms ? jtp_pkg::ST_EXIT1_IR : jtp_pkg::ST_SHIFT_IR;
         jtp_pkg::ST_EXIT1_IR:
            step = ctl.tms ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_PAUSE_IR;
         jtp_pkg::ST_PAUSE_IR:
            step = ctl.tms ? jtp_pkg::ST_EXIT2_IR : jtp_pkg::ST_PAUSE_IR;
         jtp_pkg::ST_EXIT2_IR:
            step = ctl.tms ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_SHIFT_IR;
         jtp_pkg::ST_UPD_IR:
            step = ctl.tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
         default:
            step = jtp_pkg::ST_RESET;
      endcase
   end

   // move only on a test clock rise, so a stopped test clock freezes the
   // state at either level
   assign state_d = ctl.tck_rise ? step : state_q;  // [R01] [R05] [R10]

   // power-on reset and the test reset pin both force reset at once,
   // without waiting for a system clock edge
   always_ff @(posedge i_clk or posedge i_rst or negedge ctl.trst_n)
   begin
      if (i_rst || !ctl.trst_n)
         state_q <= jtp_pkg::ST_RESET;                   // [R02] [R04]
      else
         state_q <= state_d;                             // [R22]
   end

   assign ctl.state = state_q;

endmodule : jtp_tap_fsm

`default_nettype wire

// >>> jtp_top.sv
/*
 * Test access port: pin synchronisers, controller state machine,
 * instruction chain, bypass, identification and boundary chains, and the
 * test data output stage. Assumes the host drives the test clock slow
 * enough that each half period spans several system clock cycles.
 */
`timescale 1ns/10ps
`default_nettype none

// Function
// R01: state moves only on test clock rise
// R02: low test reset forces and holds reset
// R03: entering reset loads identification instruction
// R04: power-on reset also forces reset state
// R05: five high mode selects reach reset
// R06: data input sampled on rise into chain
// R07: host changes inputs on falling edge
// R08: data output changes on falling edge
// R09: data output not driven outside shifting
// R10: stopped test clock keeps state and data
// R11: capture loads chain, shift moves bits
// R12: update copies chain to parallel register
// R13: instruction selects the data chain
// R14: state chooses instruction or data chain
// R15: unknown instructions decode as bypass
// R16: external/internal test touch no chain
// R17: host runs roughly even free clock
// R18: after reset pulls up, output undriven
// R19: software keeps pull-ups on input pins
// R20: four-bit instruction chain with parallel register
// R21: identification 1110, bypass 1111 single stage
// R22: sixteen standard states and transitions
module jtp_top #(
   parameter int          BSR_LEN = 8,             // boundary chain length
   parameter logic [31:0] ID_VAL  = 32'h0000_0001  // id value, bit 0 must be one
) (
   input  wire logic               I_SYS_CLK,       // system clock
   input  wire logic               I_RST,           // power-on reset, high
   input  wire logic               I_TCK,           // test clock pin
   input  wire logic               I_TMS,           // mode select pin
   input  wire logic               I_TDI,           // data input pin
   input  wire logic               I_TRST_N,        // test reset pin, low
   input  wire logic [BSR_LEN-1:0] I_BSR_PADS,      // pad values to sample
   output logic                    O_TDO,           // data output value
   output logic                    O_TDO_OE,        // data output enable
   output logic [BSR_LEN-1:0]      O_BSR_DATA,      // boundary update data
   output logic                    O_EXTEST,        // external test active
   output logic                    O_INTEST,        // internal test active
   output logic [4:0]              O_PULLUP_EN,     // pin pull-up enables
   output logic [4:0]              O_PULLDN_EN      // pin pull-down enables
);

   initial
   begin
      if (BSR_LEN < 1)
         $error("boundary chain length must be at least one");
      if (ID_VAL[0] != 1'b1)
         $error("identification value must end in a one");
   end

   jtp_ctl_if ctl ();

   // ---------------------------------------------------------------
   // pin synchronisers: stage one feeds stage two only; stage three
   // of the clock gives the previous level for edge finding
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   logic       tck_prev_q;
   logic       tck_rise;
   logic       tck_fall;

   always_ff @(posedge I_SYS_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         sync1_q    <= 3'h7;
         sync2_q    <= 3'h7;
         tck_prev_q <= 1'h1;
      end
      else
      begin
         sync1_q    <= {I_TDI, I_TMS, I_TCK};
         sync2_q    <= sync1_q;
         tck_prev_q <= sync2_q[0];
      end
   end

   // test reset: cleared at once by the pin, released through two
   // stages so the controller leaves reset on a clean clock edge
   logic [1:0] trst_q;

   always_ff @(posedge I_SYS_CLK or posedge I_RST or negedge I_TRST_N)
   begin
      if (I_RST || !I_TRST_N)
         trst_q <= 2'h0;                                 // [R02]
      else
         trst_q <= {trst_q[0], 1'b1};
   end

   // edges of the sampled test clock; tms and tdi are aligned with it
   assign tck_rise     = sync2_q[0] & ~tck_prev_q;
   assign tck_fall     = ~sync2_q[0] & tck_prev_q;
   assign ctl.tck_rise = tck_rise;
   assign ctl.tms      = sync2_q[1];
   assign ctl.trst_n   = trst_q[1];

   jtp_tap_fsm u_fsm (
      .i_clk (I_SYS_CLK),
      .i_rst (I_RST),
      .ctl   (ctl)
   );

   // ---------------------------------------------------------------
   // state decode: which branch is active and what it does
   wire in_reset  = (ctl.state == jtp_pkg::ST_RESET);
   wire cap_ir    = (ctl.state == jtp_pkg::ST_CAP_IR);   // [R14]
   wire shift_ir  = (ctl.state == jtp_pkg::ST_SHIFT_IR); // [R14]
   wire upd_ir    = (ctl.state == jtp_pkg::ST_UPD_IR);   // [R14]
   wire cap_dr    = (ctl.state == jtp_pkg::ST_CAP_DR);   // [R14]
   wire shift_dr  = (ctl.state == jtp_pkg::ST_SHIFT_DR); // [R14]
   wire upd_dr    = (ctl.state == jtp_pkg::ST_UPD_DR);   // [R14]

   // ---------------------------------------------------------------
   // instruction decode from the parallel register
   logic [jtp_pkg::IR_W-1:0] ir_cur;
   wire is_extest = (ir_cur == jtp_pkg::IR_EXTEST);
   wire is_intest = (ir_cur == jtp_pkg::IR_INTEST);
   wire sel_bsr   = (ir_cur == jtp_pkg::IR_SAMPLE);      // [R13]
   wire sel_id    = (ir_cur == jtp_pkg::IR_IDCODE);      // [R13] [R21]
   wire sel_none  = is_extest | is_intest;               // [R16]
   // everything not decoded above, including the bypass code, is bypass
   wire sel_byp   = ~(sel_bsr | sel_id | sel_none);      // [R15] [R21]

   // capture and shift act at a test clock rise; update acts at the fall
   // inside the update state, mid-cycle as the standard has it
   wire ir_cap  = tck_rise & cap_ir;                     // [R11]
   wire ir_sh   = tck_rise & shift_ir;                   // [R06]
   wire ir_upd  = tck_fall & upd_ir;                     // [R12]
   wire dr_cap  = tck_rise & cap_dr;
   wire dr_sh   = tck_rise & shift_dr;                   // [R06]
   wire dr_upd  = tck_fall & upd_dr;
   wire tdi_s   = sync2_q[2];

   // ---------------------------------------------------------------
   // instruction chain, held at the identification code in reset
   logic ir_so;

   jtp_shift_reg #(
      .W       (jtp_pkg::IR_W),
      .RST_VAL (jtp_pkg::IR_IDCODE)
   ) u_ir (
      .i_clk      (I_SYS_CLK),
      .i_rst      (I_RST),
      .i_hold     (in_reset),                            // [R03]
      .i_capture  (ir_cap),
      .i_shift    (ir_sh),
      .i_update   (ir_upd),
      .i_tdi      (tdi_s),
      .i_cap_data (jtp_pkg::IR_CAPTURE),
      .o_so       (ir_so),
      .o_par      (ir_cur)                               // [R20]
   );

   // bypass: one stage, its parallel side is never used
   logic byp_so;

   jtp_shift_reg #(
      .W       (1),
      .RST_VAL (1'h0)
   ) u_byp (
      .i_clk      (I_SYS_CLK),
      .i_rst      (I_RST),
      .i_hold     (1'b0),
      .i_capture  (dr_cap & sel_byp),
      .i_shift    (dr_sh & sel_byp),                     // [R21]
      .i_update   (1'b0),
      .i_tdi      (tdi_s),
      .i_cap_data (jtp_pkg::BYP_CAPTURE),
      .o_so       (byp_so),
      .o_par      ()
   );

   // identification chain: capture a constant, shift it out
   logic id_so;

   jtp_shift_reg #(
      .W       (32),
      .RST_VAL (32'h0000_0000)
   ) u_id (
      .i_clk      (I_SYS_CLK),
      .i_rst      (I_RST),
      .i_hold     (1'b0),
      .i_capture  (dr_cap & sel_id),
      .i_shift    (dr_sh & sel_id),
      .i_update   (1'b0),
      .i_tdi      (tdi_s),
      .i_cap_data (ID_VAL),
      .o_so       (id_so),
      .o_par      ()
   );

   // pads live outside this clock domain: two stages before capture,
   // so a pad moving at the capture edge cannot split the sample
   logic [BSR_LEN-1:0] pad1_q;
   logic [BSR_LEN-1:0] pad2_q;

   always_ff @(posedge I_SYS_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         pad1_q <= '0;
         pad2_q <= '0;
      end
      else
      begin
         pad1_q <= I_BSR_PADS;
         pad2_q <= pad1_q;
      end
   end

   // boundary chain: sample pads, preload the update register
   logic               bsr_so;
   logic [BSR_LEN-1:0] bsr_par;

   jtp_shift_reg #(
      .W       (BSR_LEN),
      .RST_VAL ('0)
   ) u_bsr (
      .i_clk      (I_SYS_CLK),
      .i_rst      (I_RST),
      .i_hold     (1'b0),
      .i_capture  (dr_cap & sel_bsr),
      .i_shift    (dr_sh & sel_bsr),
      .i_update   (dr_upd & sel_bsr),                    // [R12]
      .i_tdi      (tdi_s),
      .i_cap_data (pad2_q),
      .o_so       (bsr_so),
      .o_par      (bsr_par)
   );

   // ---------------------------------------------------------------
   // output selection; external and internal test leave every chain
   // alone, so nothing drives the output in their data shift
   wire dr_so     = sel_id  ? id_so  :
                    sel_bsr ? bsr_so :
                    byp_so;
   wire tdo_bit   = shift_ir ? ir_so : dr_so;            // [R14]
   wire tdo_drive = shift_ir | (shift_dr & ~sel_none);   // [R09] [R16]

   logic tdo_q;
   logic tdo_oe_q;
   logic [BSR_LEN-1:0] bsr_out_q;
   logic ext_q;
   logic int_q;
   logic [4:0] pu_q;
   logic [4:0] pd_q;

   // data output changes only on a test clock fall, so a downstream
   // device sees a settled bit at its next rise
   always_ff @(posedge I_SYS_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         tdo_q    <= 1'h0;
         tdo_oe_q <= 1'h0;                               // [R18]
      end
      else if (tck_fall)
      begin
         tdo_q    <= tdo_bit;                            // [R08]
         tdo_oe_q <= tdo_drive;                          // [R09]
      end
   end

   // test mode outputs registered to keep every port on a flip-flop;
   // costs one system cycle of lag behind the instruction register
   always_ff @(posedge I_SYS_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         bsr_out_q <= '0;
         ext_q     <= 1'h0;
         int_q     <= 1'h0;
         pu_q      <= jtp_pkg::PULLUP_RST;               // [R18]
         pd_q      <= jtp_pkg::PULLDN_RST;               // [R18]
      end
      else
      begin
         bsr_out_q <= bsr_par;
         ext_q     <= is_extest;                         // [R16]
         int_q     <= is_intest;                         // [R16]
         pu_q      <= jtp_pkg::PULLUP_RST;               // [R19]
         pd_q      <= jtp_pkg::PULLDN_RST;
      end
   end

   assign O_TDO       = tdo_q;
   assign O_TDO_OE    = tdo_oe_q;
   assign O_BSR_DATA  = bsr_out_q;
   assign O_EXTEST    = ext_q;
   assign O_INTEST    = int_q;
   assign O_PULLUP_EN = pu_q;
   assign O_PULLDN_EN = pd_q;

endmodule : jtp_top

`default_nettype wire

// >>> jtp_top_props.sv
/* checker for the test port top: edge-relative timing of its outputs.
   Assumes it is bound to every jtp_top instance of the bench. */
`timescale 1ns/10ps
`default_nettype none
module jtp_top_props #(
   parameter int BSR_LEN = 8 // boundary chain length
) (
   input wire logic               I_SYS_CLK,   // system clock
   input wire logic               I_RST,       // power-on reset
   input wire logic               I_TCK,       // test clock pin
   input wire logic               I_TRST_N,    // test reset pin
   input wire logic               O_TDO,       // data output
   input wire logic               O_TDO_OE,    // data output enable
   input wire logic [BSR_LEN-1:0] O_BSR_DATA,  // boundary update data
   input wire logic               O_EXTEST,    // external test
   input wire logic               O_INTEST,    // internal test
   input wire logic [4:0]         O_PULLUP_EN, // pull-ups
   input wire logic [4:0]         O_PULLDN_EN  // pull-downs
);
   logic [7:0] tck_h_q;  // pin samples, bit 0 newest
   logic [7:0] trst_h_q; // test reset samples
   logic       fall_w;   // a pin fall two to four edges back
   logic       late_w;   // same, one edge more slack
   logic       still_w;  // clock stopped, no test reset
   // history starts cleared so nothing counts as stopped after reset
   always_ff @(posedge I_SYS_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         tck_h_q <= 8'h00;
         trst_h_q <= 8'h00;
      end
      else
      begin
         tck_h_q <= {tck_h_q[6:0], I_TCK};
         trst_h_q <= {trst_h_q[6:0], I_TRST_N};
      end
   end
   // pin is synchronised, so changes trail the pin fall by a few edges
   assign fall_w = !tck_h_q[0] && !tck_h_q[1] && (|tck_h_q[4:2]);
   assign late_w = !tck_h_q[0] && !tck_h_q[1] && (|tck_h_q[5:2]);
   assign still_w = (&trst_h_q) && ((&tck_h_q) || !(|tck_h_q));

   pullup_const_a: assert property (@(posedge I_SYS_CLK)
      O_PULLUP_EN == jtp_pkg::PULLUP_RST) else $error("pull-ups off");
   pulldn_const_a: assert property (@(posedge I_SYS_CLK)
      O_PULLDN_EN == jtp_pkg::PULLDN_RST) else $error("pull-downs on");
   reset_quiet_a: assert property (@(posedge I_SYS_CLK)
      $fell(I_RST) |-> !O_TDO_OE && !O_EXTEST && !O_INTEST
      && O_BSR_DATA == '0) else $error("outputs active after reset");
   tdo_on_fall_a: assert property (@(posedge I_SYS_CLK)
      disable iff (I_RST) $changed(O_TDO) |-> fall_w)
      else $error("data output moved off a clock fall");
   oe_on_fall_a: assert property (@(posedge I_SYS_CLK)
      disable iff (I_RST) $changed(O_TDO_OE) |-> fall_w)
      else $error("output enable moved off a clock fall");
   bsr_on_update_a: assert property (@(posedge I_SYS_CLK)
      disable iff (I_RST) $changed(O_BSR_DATA) |-> late_w)
      else $error("boundary data moved off an update");
   test_on_update_a: assert property (@(posedge I_SYS_CLK)
      disable iff (I_RST) $rose(O_EXTEST) || $rose(O_INTEST) |-> late_w)
      else $error("test mode entered off an update");
   test_mutex_a: assert property (@(posedge I_SYS_CLK)
      disable iff (I_RST) !(O_EXTEST && O_INTEST))
      else $error("both test modes active");
   tck_stop_a: assert property (@(posedge I_SYS_CLK)
      disable iff (I_RST) still_w |-> $stable(O_TDO) && $stable(O_TDO_OE)
      && $stable(O_BSR_DATA) && $stable(O_EXTEST) && $stable(O_INTEST))
      else $error("outputs moved while clock stopped");
endmodule : jtp_top_props
bind jtp_top jtp_top_props #(.BSR_LEN(BSR_LEN)) u_props (
   .I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .I_TCK(I_TCK),
   .I_TRST_N(I_TRST_N), .O_TDO(O_TDO), .O_TDO_OE(O_TDO_OE),
   .O_BSR_DATA(O_BSR_DATA), .O_EXTEST(O_EXTEST), .O_INTEST(O_INTEST),
   .O_PULLUP_EN(O_PULLUP_EN), .O_PULLDN_EN(O_PULLDN_EN));
`default_nettype wire

// >>> tb.sv
/* self-checking bench for the test port top with the host model.
   Assumes the checker is bound through its own file. */
`timescale 1ns/10ps
`default_nettype none
module tb;
   localparam logic [31:0] ID = 32'h5a3c_0f01; // arbitrary id value
   logic clk, rst, trst_n, tck, tms, tdi, tdo, oe, ext, intst;
   logic [7:0] pads, bsr;
   logic [4:0] pu, pd;
   logic tdo_s, oe_s, off, in_sh;
   logic [31:0] d;
   int n_errors, check_count, on_n;
   jtp_top #(.BSR_LEN(8), .ID_VAL(ID)) u_dut (.I_SYS_CLK(clk),
      .I_RST(rst), .I_TCK(tck), .I_TMS(tms), .I_TDI(tdi),
      .I_TRST_N(trst_n), .I_BSR_PADS(pads), .O_TDO(tdo), .O_TDO_OE(oe),
      .O_BSR_DATA(bsr), .O_EXTEST(ext), .O_INTEST(intst),
      .O_PULLUP_EN(pu), .O_PULLDN_EN(pd));
   jtp_host_model u_host (.o_tck(tck), .o_tms(tms), .o_tdi(tdi),
      .i_tdo(tdo), .i_tdo_oe(oe));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check
   task final_report;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : final_report
   // one test clock; enable samples outside shifting must all be low
   task st(input logic m, input logic i, input int hold);
      u_host.step(m, i, hold, tdo_s, oe_s);
      if (in_sh)
         on_n += (oe_s === 1'b1);
      else
         off |= oe_s;
   endtask : st
   // full scan from reset or idle, with an optional pause after bit 1
   task shift(input logic ir, input logic [31:0] din, input int n,
              input logic pz, input logic eo);
      in_sh = 1'b0;
      off = 1'b0;
      on_n = 0;
      d = '0;
      st(0, 1, 0);
      st(1, 1, 0);
      if (ir)
         st(1, 1, 0);
      st(0, 1, 0);
      st(0, 1, 0);
      for (int i = 0; i < n; i++)
      begin
         in_sh = 1'b1;
         st(i == n - 1 || (pz && i == 1), din[i], 0);
         d[i] = tdo_s;
         in_sh = 1'b0;
         if (pz && i == 1)
         begin
            st(0, 1, 0);
            st(1, 1, 300);
            st(0, 1, 0);
         end
      end
      st(1, 1, 0);
      st(0, 1, 0);
      check(32'(on_n), eo ? 32'(n) : 32'h0);
      check(32'(off), 32'h0);
   endtask : shift
   task do_reset;
      @(posedge clk);
      #1 rst = 1'b1;
      repeat (3) @(posedge clk);
      #1 rst = 1'b0;
      repeat (3) @(posedge clk);
      check(32'({oe, ext, intst, bsr}), 32'h0);
      check(32'({pu, pd}), 32'h3e0);
   endtask : do_reset
   task read_id;
      shift(0, 32'h0, 32, 0, 1);
      check(d, ID);
   endtask : read_id
   task t_bypass;
      logic [3:0] codes [6];
      codes = '{4'hf, 4'h8, 4'ha, 4'hb, 4'hc, 4'h3};
      foreach (codes[k])
      begin
         shift(1, 32'(codes[k]), 4, 0, 1);
         check(d, 32'h1);
         shift(0, 32'hb5, 8, 1, 1);
         check(d, 32'h6a);
      end
   endtask : t_bypass
   task t_sample;
      @(posedge clk);
      #1 pads = 8'h3c;
      shift(1, 32'h2, 4, 0, 1);
      shift(0, 32'ha6, 8, 1, 1);
      check(d, 32'h3c);
      check(32'(bsr), 32'ha6);
   endtask : t_sample
   task t_extest;
      shift(1, 32'h0, 4, 0, 1);
      check(32'({ext, intst}), 32'h2);
      shift(0, 32'h0, 8, 1, 0);
      check(d, 32'hff);
      check(32'(bsr), 32'ha6);
      shift(1, 32'h1, 4, 0, 1);
      check(32'({ext, intst}), 32'h1);
   endtask : t_extest
   task t_trst;
      @(posedge clk);
      #1 trst_n = 1'b0;
      repeat (10) @(posedge clk);
      check(32'(intst), 32'h0);
      #1 trst_n = 1'b1;
      repeat (5) @(posedge clk);
      read_id();
   endtask : t_trst
   task t_tms_reset;
      shift(1, 32'hf, 4, 0, 1);
      st(0, 1, 0);
      st(1, 1, 0);
      st(0, 1, 0);
      st(0, 1, 0);
      repeat (5) st(1, 1, 0);
      read_id();
   endtask : t_tms_reset
   initial
   begin
      #300us;
      n_errors++;
      final_report();
   end
   initial
   begin
      rst = 1'b0;
      trst_n = 1'b1;
      pads = 8'h00;
      n_errors = 0;
      check_count = 0;
      in_sh = 1'b0;
      // a clean rising reset edge before the first clock edge
      #1 rst = 1'b1;
      do_reset();
      read_id();
      t_bypass();
      t_sample();
      t_extest();
      t_trst();
      t_tms_reset();
      t_sample();
      do_reset();
      read_id();
      final_report();
   end
endmodule : tb
`default_nettype wire
